// ---- design/baud_tick.sv ----
/*
 * Tick generator: one pulse every divisor clocks while run is high.
 * Assumes divisor is stable while running; zero counts as one.
 */
`timescale 1ns/1ps
module baud_tick (
   input wire logic clock,
   input wire logic rstn,
   input wire logic run,
   input wire logic [15:0] divisor,
   output logic tick
);
   logic [15:0] count;
   logic [15:0] lastCount;

   assign lastCount = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;

   // Held in reset while idle so the first tick lines up with the frame.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (!run) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (count >= lastCount) begin
         count <= 16'h0000;
         tick <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// ---- design/uart_frame_check_addr_match.sv ----
/*
 * Enhanced serial port with framing error detection and automatic address
 * recognition, reached over APB.
 * Assumes one clock, APB master per the AMBA protocol, rxd already synchronous.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module uart_frame_check_addr_match (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic rxdOut,
   output logic rxdOe,
   output logic txd,
   output logic irq
);
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxState_t;
   typedef enum {TX_IDLE, TX_BITS} txState_t;

   logic modeBitHigh, modeBitLow, multiprocEnable, receiveEnable, txNinth, rxNinth;
   logic transmitDoneFlag, receiveDoneFlag, framingErrorFlag;
   logic [7:0] givenAddressReg, addressMaskReg, powerControlReg, rxBuffer;
   logic [31:0] baudReg;
   logic [2:0] irqStatus, irqMask;
   logic [31:0] readValue;
   logic readHit, setup, wrEn;
   logic framingCheckSelect, mode0, mode1, ninthMode;
   logic [15:0] rxDiv, txDiv;
   logic rxTick, txTick, rxSample, txBoundary;
   rxState_t rxState;
   txState_t txState;
   logic [3:0] rxPhase, rxCount, txPhase, txLeft, bitLast;
   logic [8:0] rxShift, shiftIn;
   logic [10:0] txShift;
   logic rxdPrev, rxKept;
   logic rxDoneEvt, txDoneEvt, frameErrEvt, rb8Evt, rb8Val;
   logic lastBit, lateCheck, finishEarly, finishLate, keepFrame;
   logic [7:0] finishByte;
   logic finishNinth;

   // Given address compare, or broadcast compare with the OR as reference.
   function automatic logic maskedMatch(input logic [7:0] a, input logic [7:0] ref8,
                                        input logic [7:0] care);
      return ((a ^ ref8) & care) == 8'h00;
   endfunction

   function automatic logic [15:0] divFor(input logic m0, input logic hi, input logic lo,
                                          input logic fast, input logic [15:0] prog);
      if (m0) begin
         return uart_pkg::MODE0_HALF_BIT;
      end else if (hi && !lo) begin
         return fast ? uart_pkg::MODE2_SIXTEENTH_FAST : uart_pkg::MODE2_SIXTEENTH;
      end
      return prog;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign framingCheckSelect = powerControlReg[uart_pkg::PC_FRAMING_CHECK];
   assign mode0 = !modeBitHigh && !modeBitLow;
   assign mode1 = !modeBitHigh && modeBitLow;
   assign ninthMode = modeBitHigh;
   assign bitLast = mode0 ? 4'h1 : 4'hf;
   assign setup = psel && !penable;
   assign wrEn = psel && penable && pready && pwrite;
   // Independent rates for the two directions in the variable modes.
   assign rxDiv = divFor(mode0, modeBitHigh, modeBitLow,
                         powerControlReg[uart_pkg::PC_DOUBLE_RATE], baudReg[15:0]);
   assign txDiv = divFor(mode0, modeBitHigh, modeBitLow,
                         powerControlReg[uart_pkg::PC_DOUBLE_RATE], baudReg[31:16]);

   baud_tick rxGen (
      .clock(clock),
      .rstn(rstn),
      .run(rxState != RX_IDLE),
      .divisor(rxDiv),
      .tick(rxTick)
   );

   baud_tick txGen (
      .clock(clock),
      .rstn(rstn),
      .run(txState == TX_BITS),
      .divisor(txDiv),
      .tick(txTick)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      readHit = 1'b1;
      readValue = 32'h0000_0000;
      case (paddr)
         uart_pkg::regAddr(uart_pkg::SERIAL_CONTROL_IDX): begin
            readValue[7] = framingCheckSelect ? framingErrorFlag : modeBitHigh;
            readValue[6:0] = {modeBitLow, multiprocEnable, receiveEnable, txNinth, rxNinth,
                              transmitDoneFlag, receiveDoneFlag};
         end
         uart_pkg::regAddr(uart_pkg::GIVEN_ADDRESS_IDX): readValue[7:0] = givenAddressReg;
         uart_pkg::regAddr(uart_pkg::ADDRESS_MASK_IDX): readValue[7:0] = addressMaskReg;
         uart_pkg::POWER_CONTROL_ADDR: readValue[7:0] = powerControlReg;
         uart_pkg::DATA_ADDR: readValue[7:0] = rxBuffer;
         uart_pkg::BAUD_ADDR: readValue = baudReg;
         uart_pkg::IRQ_STATUS_ADDR: readValue[2:0] = irqStatus;
         uart_pkg::IRQ_MASK_ADDR: readValue[2:0] = irqMask;
         default: readHit = 1'b0;
      endcase
   end

   // One wait-free access phase: the answer is prepared during setup.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !readHit;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : readValue;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         givenAddressReg <= uart_pkg::GIVEN_ADDRESS_RESET;
         addressMaskReg <= uart_pkg::ADDRESS_MASK_RESET;
         powerControlReg <= uart_pkg::POWER_CONTROL_RESET;
         baudReg <= uart_pkg::BAUD_RESET;
         irqMask <= uart_pkg::IRQ_MASK_RESET;
      end else if (wrEn) begin
         case (paddr)
            uart_pkg::regAddr(uart_pkg::GIVEN_ADDRESS_IDX): givenAddressReg <= pwdata[7:0];
            uart_pkg::regAddr(uart_pkg::ADDRESS_MASK_IDX): addressMaskReg <= pwdata[7:0];
            uart_pkg::POWER_CONTROL_ADDR: powerControlReg <= pwdata[7:0];
            uart_pkg::BAUD_ADDR: baudReg <= pwdata;
            uart_pkg::IRQ_MASK_ADDR: irqMask <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial control: hardware events are applied after the software write,
   // so a flag set in the clearing cycle survives.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {modeBitHigh, modeBitLow, multiprocEnable, receiveEnable, txNinth, rxNinth,
          transmitDoneFlag, receiveDoneFlag} <= uart_pkg::SERIAL_CONTROL_RESET;
         framingErrorFlag <= 1'b0;
      end else begin
         if (wrEn && paddr == uart_pkg::regAddr(uart_pkg::SERIAL_CONTROL_IDX)) begin
            if (framingCheckSelect) begin
               framingErrorFlag <= pwdata[uart_pkg::SC_BIT7];
            end else begin
               modeBitHigh <= pwdata[uart_pkg::SC_BIT7];
            end
            modeBitLow <= pwdata[uart_pkg::SC_MODE_LOW];
            multiprocEnable <= pwdata[uart_pkg::SC_MULTIPROC];
            receiveEnable <= pwdata[uart_pkg::SC_RX_ENABLE];
            txNinth <= pwdata[uart_pkg::SC_TX_NINTH];
            rxNinth <= pwdata[uart_pkg::SC_RX_NINTH];
            transmitDoneFlag <= pwdata[uart_pkg::SC_TX_DONE];
            receiveDoneFlag <= pwdata[uart_pkg::SC_RX_DONE];
         end
         if (rxDoneEvt) begin
            receiveDoneFlag <= 1'b1;
         end
         if (txDoneEvt) begin
            transmitDoneFlag <= 1'b1;
         end
         if (frameErrEvt) begin
            framingErrorFlag <= 1'b1;
         end
         if (rb8Evt) begin
            rxNinth <= rb8Val;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irqStatus <= 3'h0;
         irq <= 1'b0;
      end else begin
         irqStatus <= (wrEn && paddr == uart_pkg::IRQ_STATUS_ADDR) ?
                      (irqStatus & ~pwdata[2:0]) | {frameErrEvt, txDoneEvt, rxDoneEvt} :
                      irqStatus | {frameErrEvt, txDoneEvt, rxDoneEvt};
         irq <= |(irqStatus & irqMask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign shiftIn = {rxd, rxShift[8:1]};
   assign rxSample = rxTick && (rxPhase == ((rxState == RX_START) ? uart_pkg::START_MIDDLE :
                                            bitLast));

   always_comb begin
      lastBit = rxCount == (ninthMode ? 4'h8 : 4'h7);
      lateCheck = framingCheckSelect || (mode1 && multiprocEnable);
      finishEarly = rxState == RX_DATA && rxSample && lastBit && (mode0 || !lateCheck);
      finishLate = rxState == RX_STOP && rxSample && lateCheck;
      finishByte = finishEarly ? (ninthMode ? shiftIn[7:0] : shiftIn[8:1]) :
                   (ninthMode ? rxShift[7:0] : rxShift[8:1]);
      finishNinth = mode1 ? rxd : (finishEarly ? shiftIn[8] : rxShift[8]);
      keepFrame = 1'b0;
      if ((finishEarly || finishLate) && !receiveDoneFlag) begin
         if (!multiprocEnable || mode0) begin
            keepFrame = 1'b1;
         end else begin
            // Address filtering; a mismatch leaves receive done untouched.
            keepFrame = (mode1 ? finishNinth : (finishNinth && ninthMode)) &&
                        (maskedMatch(finishByte, givenAddressReg, addressMaskReg) ||
                         maskedMatch(finishByte, givenAddressReg | addressMaskReg,
                                     givenAddressReg | addressMaskReg));
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxdPrev <= 1'b1;
      end else begin
         rxdPrev <= rxd;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxState <= RX_IDLE;
         rxPhase <= 4'h0;
         rxCount <= 4'h0;
         rxShift <= 9'h000;
         rxBuffer <= 8'h00;
         rxKept <= 1'b0;
         rxDoneEvt <= 1'b0;
         frameErrEvt <= 1'b0;
         rb8Evt <= 1'b0;
         rb8Val <= 1'b0;
      end else begin
         rxDoneEvt <= keepFrame;
         frameErrEvt <= 1'b0;
         rb8Evt <= 1'b0;
         if (keepFrame) begin
            rxBuffer <= finishByte;
            rxKept <= 1'b1;
            rb8Evt <= !mode0 && (ninthMode || finishLate);
            rb8Val <= finishNinth;
         end
         if (rxTick) begin
            rxPhase <= rxSample ? 4'h0 : rxPhase + 4'h1;
         end
         case (rxState)
            RX_IDLE: begin
               rxPhase <= 4'h0;
               rxCount <= 4'h0;
               rxKept <= 1'b0;
               if (mode0) begin
                  // Half duplex: reception waits for an idle transmitter.
                  if (receiveEnable && !receiveDoneFlag && txState == TX_IDLE) begin
                     rxState <= RX_DATA;
                  end
               end else if (receiveEnable && rxdPrev && !rxd) begin
                  rxState <= RX_START;
               end
            end
            RX_START: begin
               if (rxSample) begin
                  rxState <= rxd ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rxSample) begin
                  rxShift <= shiftIn;
                  rxCount <= rxCount + 4'h1;
                  if (lastBit) begin
                     rxState <= mode0 ? RX_IDLE : RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rxSample) begin
                  rxState <= RX_IDLE;
                  frameErrEvt <= framingCheckSelect && !rxd;
                  if (mode1 && !multiprocEnable && rxKept) begin
                     rb8Evt <= 1'b1;
                     rb8Val <= rxd;
                  end
               end
            end
            default: rxState <= RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // A data write while a frame is going out is ignored.
   assign txBoundary = txTick && txPhase == bitLast;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         txState <= TX_IDLE;
         txShift <= 11'h7ff;
         txLeft <= 4'h0;
         txPhase <= 4'h0;
         txDoneEvt <= 1'b0;
      end else begin
         txDoneEvt <= txState == TX_BITS && txBoundary &&
                      txLeft == (mode0 ? 4'h1 : 4'h2);
         case (txState)
            TX_IDLE: begin
               txPhase <= 4'h0;
               if (wrEn && paddr == uart_pkg::DATA_ADDR) begin
                  txState <= TX_BITS;
                  if (mode0) begin
                     txShift <= {3'h7, pwdata[7:0]};
                     txLeft <= 4'h8;
                  end else if (ninthMode) begin
                     txShift <= {1'b1, txNinth, pwdata[7:0], 1'b0};
                     txLeft <= 4'hb;
                  end else begin
                     txShift <= {2'h3, pwdata[7:0], 1'b0};
                     txLeft <= 4'ha;
                  end
               end
            end
            TX_BITS: begin
               if (txTick) begin
                  txPhase <= txBoundary ? 4'h0 : txPhase + 4'h1;
               end
               if (txBoundary) begin
                  txShift <= {1'b1, txShift[10:1]};
                  txLeft <= txLeft - 4'h1;
                  if (txLeft == 4'h1) begin
                     txState <= TX_IDLE;
                  end
               end
            end
            default: txState <= TX_IDLE;
         endcase
      end
   end

   // Mode 0 puts the shift clock on txd and the data on the two-way pin.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         txd <= 1'b1;
         rxdOut <= 1'b1;
         rxdOe <= 1'b0;
      end else if (mode0) begin
         txd <= (txState == TX_BITS) ? txPhase[0] : ((rxState == RX_DATA) ? rxPhase[0] : 1'b1);
         rxdOut <= txShift[0];
         rxdOe <= txState == TX_BITS;
      end else begin
         txd <= (txState == TX_BITS) ? txShift[0] : 1'b1;
         rxdOut <= 1'b1;
         rxdOe <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   a_stop_error_sets: assert property (
      (rxState == RX_STOP && rxSample && framingCheckSelect && !rxd) |-> ##2 framingErrorFlag)
      else $error("framing error flag not set after bad stop bit");
   a_error_sticky: assert property (
      (framingErrorFlag && !(wrEn && paddr == uart_pkg::regAddr(uart_pkg::SERIAL_CONTROL_IDX)))
      |=> framingErrorFlag)
      else $error("framing error flag cleared without software");
   a_error_async_only: assert property (
      frameErrEvt |-> $past(!mode0) && $past(framingCheckSelect))
      else $error("framing error raised outside checked async modes");
   a_done_at_stop: assert property (
      (rxDoneEvt && framingCheckSelect && $past(framingCheckSelect) && !$past(mode0))
      |-> $past(rxState) == RX_STOP)
      else $error("receive done not at stop bit while checking");
   a_address_filter: assert property (
      (rxDoneEvt && $past(multiprocEnable) && !$past(mode0) &&
       $stable(givenAddressReg) && $stable(addressMaskReg))
      |-> maskedMatch(rxBuffer, givenAddressReg, addressMaskReg) ||
          maskedMatch(rxBuffer, givenAddressReg | addressMaskReg,
                      givenAddressReg | addressMaskReg))
      else $error("unmatched address frame accepted");
   a_reset_addresses: assert property (@(posedge clock)
      $rose(rstn) |-> givenAddressReg == uart_pkg::GIVEN_ADDRESS_RESET &&
                      addressMaskReg == uart_pkg::ADDRESS_MASK_RESET)
      else $error("address registers not cleared in reset");
   a_bit7_view: assert property (
      (setup && !pwrite && paddr == uart_pkg::regAddr(uart_pkg::SERIAL_CONTROL_IDX))
      |=> prdata[7] == $past(framingCheckSelect ? framingErrorFlag : modeBitHigh))
      else $error("control bit 7 shows the wrong field");
   a_tx_starts: assert property (
      (wrEn && paddr == uart_pkg::DATA_ADDR && txState == TX_IDLE)
      |=> txState == TX_BITS ##1 (txState == TX_BITS)[*3])
      else $error("transmitter did not start on data write");
   a_irq_level: assert property (
      (|(irqStatus & irqMask)) |=> irq)
      else $error("interrupt not raised for unmasked status");

   c_duplex: cover property (rxState == RX_DATA && txState == TX_BITS && !mode0);
   c_framing: cover property (frameErrEvt);
   c_dropped: cover property ((finishEarly || finishLate) && multiprocEnable && !keepFrame);
   c_accepted: cover property (rxDoneEvt && multiprocEnable);
endmodule

// ---- design/uart_pkg.sv ----
/*
 * Shared constants for the enhanced serial port: register addresses, field
 * positions, reset values and fixed divider counts.
 * Assumes a 12-bit APB byte address and 32-bit data words.
 */
package uart_pkg;

   // Printed register indices; the byte address is four times the index.
   localparam logic [7:0] SERIAL_CONTROL_IDX = 8'h98;
   localparam logic [7:0] GIVEN_ADDRESS_IDX = 8'ha9;
   localparam logic [7:0] ADDRESS_MASK_IDX = 8'hb9;

   localparam logic [11:0] POWER_CONTROL_ADDR = 12'h400;
   localparam logic [11:0] DATA_ADDR = 12'h404;
   localparam logic [11:0] BAUD_ADDR = 12'h408;
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h40c;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h410;

   // Serial control field positions.
   localparam int SC_BIT7 = 7;
   localparam int SC_MODE_LOW = 6;
   localparam int SC_MULTIPROC = 5;
   localparam int SC_RX_ENABLE = 4;
   localparam int SC_TX_NINTH = 3;
   localparam int SC_RX_NINTH = 2;
   localparam int SC_TX_DONE = 1;
   localparam int SC_RX_DONE = 0;

   // Power control field positions.
   localparam int PC_DOUBLE_RATE = 7;
   localparam int PC_FRAMING_CHECK = 6;

   // Interrupt status and mask bits.
   localparam int IRQ_RX_DONE = 0;
   localparam int IRQ_TX_DONE = 1;
   localparam int IRQ_FRAMING = 2;

   localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
   localparam logic [7:0] GIVEN_ADDRESS_RESET = 8'h00;
   localparam logic [7:0] ADDRESS_MASK_RESET = 8'h00;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [31:0] BAUD_RESET = 32'h000d_000d;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // Fixed rates: mode 0 bit is 12 clocks (two halves), mode 2 bit is 64
   // or 32 clocks, counted in sixteen ticks and sampled once.
   localparam logic [15:0] MODE0_HALF_BIT = 16'h0006;
   localparam logic [15:0] MODE2_SIXTEENTH = 16'h0004;
   localparam logic [15:0] MODE2_SIXTEENTH_FAST = 16'h0002;
   localparam logic [3:0] START_MIDDLE = 4'h7;

   function automatic logic [11:0] regAddr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

endpackage

// ---- verification/line_node.sv ----
/*
 * Model of a remote node on the shared serial line: it sends frames into rxd
 * and catches the frames that the port sends on txd.
 * Assumes the receiver counts BIT_CLOCKS system clocks per bit; the line idles high.
 */
`timescale 1ns/1ps
module line_node #(
   parameter int BIT_CLOCKS = 32
) (
   input wire logic clock,
   input wire logic txd,
   output logic rxd
);
   initial rxd = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Start, eight data bits least significant first, optional ninth bit, stop.
   // The stop level is a choice so that a broken frame can be sent on purpose.
   task automatic sendFrame(input logic [7:0] d, input logic nine, input logic useNine,
                            input logic stop);
      logic [10:0] bits;
      int n;
      bits = {stop, nine, d, 1'b0};
      n = useNine ? 11 : 10;
      if (!useNine) begin
         bits[9] = stop;
      end
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         rxd <= bits[i];
         repeat (BIT_CLOCKS - 1) @(posedge clock);
      end
      @(posedge clock);
      rxd <= 1'b1;
      repeat (BIT_CLOCKS) @(posedge clock);
   endtask

   // Samples mid-bit; it returns one bit after the stop so the sender is idle again.
   task automatic recvFrame(output logic [7:0] d, output logic stop);
      do begin
         @(posedge clock);
      end while (txd !== 1'b0);
      repeat (BIT_CLOCKS / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLOCKS) @(posedge clock);
         d[i] = txd;
      end
      repeat (BIT_CLOCKS) @(posedge clock);
      stop = txd;
      repeat (BIT_CLOCKS) @(posedge clock);
   endtask
endmodule

// ---- verification/tb_uart_frame_check_addr_match.sv ----
/*
 * Self-checking bench for the serial port: APB master tasks and one task per scenario.
 * Assumes the line node model drives rxd and the baud divisor is set to two clocks.
 */
`timescale 1ns/1ps
module tb_uart_frame_check_addr_match;
   localparam logic [11:0] SC = {2'b00, uart_pkg::SERIAL_CONTROL_IDX, 2'b00};
   localparam logic [11:0] GA = {2'b00, uart_pkg::GIVEN_ADDRESS_IDX, 2'b00};
   localparam logic [11:0] AM = {2'b00, uart_pkg::ADDRESS_MASK_IDX, 2'b00};
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr, rxd, irq, txd, rxdOut, rxdOe;
   int fails = 0;
   int num_checks = 0;

   always #20 clock = ~clock;

   uart_frame_check_addr_match u_uart_frame_check_addr_match (.clock(clock), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .rxdOut(rxdOut),
      .rxdOe(rxdOe), .txd(txd), .irq(irq));
   line_node #(.BIT_CLOCKS(32)) u_line_node (.clock(clock), .txd(txd), .rxd(rxd));

   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      num_checks++;
      if ((got & m) !== (exp & m)) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & m, exp & m);
      end
   endtask

   task automatic summarize();
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic testReset();
      apb(1'b0, GA, 32'h0);
      chk(rdata, 32'h0, 32'hffff_ffff);
      apb(1'b0, AM, 32'h0);
      chk(rdata, 32'h0, 32'hffff_ffff);
      apb(1'b0, 12'hffc, 32'h0);
      chk({31'h0, rerr}, 32'h1, 32'h1);
      apb(1'b1, uart_pkg::BAUD_ADDR, 32'h0002_0002);
   endtask

   // Clearing receive done rewrites bit 7 too, so a one is written to keep the flag.
   task automatic testFraming();
      apb(1'b1, uart_pkg::POWER_CONTROL_ADDR, 32'h40);
      apb(1'b1, SC, 32'h50);
      u_line_node.sendFrame(8'h5a, 1'b0, 1'b0, 1'b0);
      apb(1'b0, SC, 32'h0);
      chk(rdata, 32'h81, 32'h81);
      apb(1'b1, SC, 32'hd0);
      u_line_node.sendFrame(8'ha5, 1'b0, 1'b0, 1'b1);
      apb(1'b0, SC, 32'h0);
      chk(rdata, 32'hd1, 32'hd1);
      apb(1'b0, uart_pkg::DATA_ADDR, 32'h0);
      chk(rdata, 32'ha5, 32'hff);
      apb(1'b1, SC, 32'h50);
      apb(1'b0, SC, 32'h0);
      chk(rdata, 32'h0, 32'h81);
   endtask

   task automatic testAddress();
      logic [7:0] addrs [3];
      logic hits [3];
      addrs = '{8'hf3, 8'hff, 8'hf5};
      hits = '{1'b0, 1'b1, 1'b1};
      apb(1'b1, uart_pkg::POWER_CONTROL_ADDR, 32'h0);
      apb(1'b1, GA, 32'hf1);
      apb(1'b1, AM, 32'hfa);
      apb(1'b1, uart_pkg::IRQ_MASK_ADDR, 32'h1);
      // Status left over from the framing frames would otherwise show on irq.
      apb(1'b1, uart_pkg::IRQ_STATUS_ADDR, 32'h7);
      apb(1'b1, SC, 32'hf0);
      apb(1'b0, SC, 32'h0);
      chk(rdata, 32'hf0, 32'hf1);
      for (int i = 0; i < 3; i++) begin
         u_line_node.sendFrame(addrs[i], 1'b1, 1'b1, 1'b1);
         apb(1'b0, SC, 32'h0);
         chk(rdata, {31'h0, hits[i]}, 32'h1);
         chk({31'h0, irq}, {31'h0, hits[i]}, 32'h1);
         apb(1'b1, SC, 32'hf0);
         apb(1'b1, uart_pkg::IRQ_STATUS_ADDR, 32'h7);
      end
   endtask

   // One mode 1 frame caught by the line node, then one mode 0 byte on the data pin.
   task automatic testTransmit();
      logic [7:0] got;
      logic stopBit;
      apb(1'b1, SC, 32'h40);
      apb(1'b1, uart_pkg::IRQ_STATUS_ADDR, 32'h7);
      chk({30'h0, rxdOe, rxdOut}, 32'h1, 32'h3);
      apb(1'b1, uart_pkg::DATA_ADDR, 32'h3c);
      u_line_node.recvFrame(got, stopBit);
      chk({23'h0, stopBit, got}, 32'h13c, 32'h1ff);
      apb(1'b0, uart_pkg::IRQ_STATUS_ADDR, 32'h0);
      chk(rdata, 32'h2, 32'h2);
      apb(1'b1, SC, 32'h0);
      apb(1'b1, uart_pkg::DATA_ADDR, 32'h5a);
      repeat (2) @(posedge clock);
      chk({30'h0, rxdOe, rxdOut}, 32'h2, 32'h3);
      repeat (120) @(posedge clock);
      apb(1'b0, SC, 32'h0);
      chk(rdata, 32'h2, 32'h2);
      chk({31'h0, rxdOe}, 32'h0, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      testReset();
      testFraming();
      testAddress();
      testTransmit();
      summarize();
   end

   // Each frame takes under 400 clocks; this span leaves ample room.
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      summarize();
   end
endmodule
